//--- rxmc_pkg.sv
/*
  rxmc_pkg: constants, types and field layout for the receive master clock
  and slot mask block. Assumes a 32-bit APB register bus on mclk.
*/
// Functional notes
// - source select 0: master clock taken from external master clock pin.
// - source select 1: master clock made by the programmable high divider.
// - invert bit 0: master clock feeds bit clock divider unchanged.
// - invert bit 1: master clock inverted before the bit clock divider.
// - internal bit clock at divide-by-1 passes master clock to pin.
// - 12-bit master divide field divides auxiliary clock by value plus one.
// - reserved control bits read zero, ignore writes; software writes zero.
// - mask bit n at 0: no data shifted in during slot n.
// - mask bit n at 1: data shifted in during slot n.
// - 5-bit bit clock ratio divides master clock by value plus one.
// - bit clock from divider when internal, else from external pin.
package rxmc_pkg;
  localparam logic [7:0]  RXMC_OFF_BITCTL  = 8'h70;
  localparam logic [7:0]  RXMC_OFF_MCLKCTL = 8'h74;
  localparam logic [7:0]  RXMC_OFF_SLOTMSK = 8'h78;
  localparam int          RXMC_POS_SRC     = 15;
  localparam int          RXMC_POS_INV     = 14;
  localparam int          RXMC_POS_BSRC    = 5;
  localparam int          RXMC_HDIV_W      = 12;
  localparam int          RXMC_BDIV_W      = 5;
  localparam logic        RXMC_RST_SRC     = 1'b1;
  localparam logic        RXMC_RST_INV     = 1'b0;
  localparam logic [11:0] RXMC_RST_HDIV    = 12'h000;
  localparam logic [31:0] RXMC_RST_MASK    = 32'h0000_0000;
  localparam logic        RXMC_RST_BSRC    = 1'b0;
  localparam logic [4:0]  RXMC_RST_BDIV    = 5'h00;
  localparam int          RXMC_SYNC_STAGES = 2;

  typedef struct packed {
    logic        src_sel;
    logic        invert;
    logic [11:0] hdiv;
    logic        bsrc_sel;
    logic [4:0]  bdiv;
  } rxmc_cfg_s;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } rxmc_apb_req_s;

  typedef enum logic [1:0] {
    RXMC_SL_IDLE = 2'b00,
    RXMC_SL_RUN  = 2'b01
  } rxmc_slot_state_e;
endpackage

//--- rxmc_sync.sv
/*
  rxmc_sync: two-flop synchroniser bank for asynchronous pin inputs.
  Assumes inputs come from outside the mclk domain.
*/
`timescale 1ns/1ps
module rxmc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             mclk,
  input  wire logic             reset_n,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;

  initial begin
    if (WIDTH < 1) $error("rxmc_sync: WIDTH must be at least 1");
  end

  // first stage is read only by the second
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      stage1_ff <= '0;
      stage2_ff <= '0;
    end else if (clk_en) begin
      stage1_ff <= async_in;
      stage2_ff <= stage1_ff;
    end
  end

  assign sync_out = stage2_ff;
endmodule

//--- rxmc_top.sv
/*
  rxmc_top: receive master clock generator, bit clock divider, and
  receive slot enable mask with slot counter, behind an APB slave.
  Assumes auxiliary clock, external clocks and frame sync arrive as
  slow asynchronous levels sampled on mclk (40 MHz); generated clocks
  are mclk-sampled waveforms for the downstream serializer.
*/
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
module rxmc_top
  import rxmc_pkg::*;
#(
  parameter int SLOTS = 32
) (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        auxiliary_source_clock,
  input  wire logic        rx_master_clock_in,
  output logic             rx_master_clock_out,
  output logic             rx_master_clock_oe,
  input  wire logic        rx_bit_clock_in,
  output logic             rx_bit_clock_out,
  output logic             rx_bit_clock_oe,
  input  wire logic        rx_frame_start,
  output logic [4:0]       rx_slot_index,
  output logic             rx_slot_shift_en
);
  initial begin
    if (SLOTS < 2 || SLOTS > 32) $error("rxmc_top: SLOTS must be 2..32");
  end

  // ---------------- register bus ----------------
  rxmc_apb_req_s req;
  rxmc_cfg_s     cfg_ff;
  logic [31:0]   rx_slot_active_bits_ff;
  logic [31:0]   nxt_prdata;
  logic [31:0]   prdata_ff;

  assign req = '{psel, penable, pwrite, paddr, pwdata};

  // address decode and strobes
  wire hit_bit  = (req.paddr == RXMC_OFF_BITCTL);
  wire hit_mclk = (req.paddr == RXMC_OFF_MCLKCTL);
  wire hit_mask = (req.paddr == RXMC_OFF_SLOTMSK);
  wire hit_any  = hit_bit | hit_mclk | hit_mask;
  wire access   = req.psel & req.penable & clk_en;
  wire wr_stb   = access & req.pwrite & hit_any;

  // read views; reserved bits stay zero
  wire [31:0] rd_mclk = {16'h0000, cfg_ff.src_sel, cfg_ff.invert,
                         2'b00, cfg_ff.hdiv};
  wire [31:0] rd_bit  = {26'h0000000, cfg_ff.bsrc_sel, cfg_ff.bdiv};
  assign nxt_prdata = hit_mclk ? rd_mclk :
                      hit_bit  ? rd_bit  :
                      hit_mask ? rx_slot_active_bits_ff : 32'h0000_0000;

  // zero-wait answer; unmapped addresses flag an error
  assign pready  = 1'b1;
  assign pslverr = req.psel & req.penable & ~hit_any;
  assign prdata  = prdata_ff;

  // read data register, loaded in setup phase
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      prdata_ff <= 32'h0000_0000;
    end else if (clk_en && req.psel && !req.penable && !req.pwrite) begin
      prdata_ff <= nxt_prdata;
    end
  end

  // control registers; only defined fields are stored
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_ff <= '{RXMC_RST_SRC, RXMC_RST_INV, RXMC_RST_HDIV,
                  RXMC_RST_BSRC, RXMC_RST_BDIV};
      rx_slot_active_bits_ff <= RXMC_RST_MASK;
    end else if (wr_stb) begin
      if (hit_mclk) begin
        cfg_ff.src_sel <= req.pwdata[RXMC_POS_SRC];
        cfg_ff.invert  <= req.pwdata[RXMC_POS_INV];
        cfg_ff.hdiv    <= req.pwdata[RXMC_HDIV_W-1:0];
      end
      if (hit_bit) begin
        cfg_ff.bsrc_sel <= req.pwdata[RXMC_POS_BSRC];
        cfg_ff.bdiv     <= req.pwdata[RXMC_BDIV_W-1:0];
      end
      if (hit_mask) begin
        rx_slot_active_bits_ff <= req.pwdata;
      end
    end
  end

  // ---------------- pin synchronisers ----------------
  logic [3:0] pins_sync;
  rxmc_sync #(.WIDTH(4)) u_sync (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .clk_en   (clk_en),
    .async_in ({auxiliary_source_clock, rx_master_clock_in,
                rx_bit_clock_in, rx_frame_start}),
    .sync_out (pins_sync)
  );
  wire aux_s   = pins_sync[3];
  wire hext_s  = pins_sync[2];
  wire bext_s  = pins_sync[1];
  wire frame_s = pins_sync[0];

  // ---------------- master clock divider ----------------
  // divides the auxiliary clock by hdiv+1 using its rising edges
  logic        aux_d_ff;
  logic [11:0] hcnt_ff;
  logic        hclk_gen_ff;
  wire         aux_rise = aux_s & ~aux_d_ff;
  wire [12:0]  hdiv_n   = {1'b0, cfg_ff.hdiv} + 13'h0001;
  wire [11:0]  hhalf    = hdiv_n[12:1];
  // >= so a count left above a newly shrunk ratio wraps at once
  wire [11:0]  nxt_hcnt = (hcnt_ff >= cfg_ff.hdiv) ? 12'h000
                                                   : hcnt_ff + 12'h001;
  wire         nxt_hclk = (cfg_ff.hdiv == 12'h000) ? aux_s
                                                   : (nxt_hcnt < hhalf);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      aux_d_ff    <= 1'b0;
      hcnt_ff     <= 12'h000;
      hclk_gen_ff <= 1'b0;
    end else if (clk_en) begin
      aux_d_ff <= aux_s;
      if (cfg_ff.hdiv == 12'h000) begin
        hclk_gen_ff <= aux_s; // divide-by-1 follows the source
      end else if (aux_rise) begin
        hcnt_ff     <= nxt_hcnt;
        hclk_gen_ff <= nxt_hclk;
      end
    end
  end

  // master clock selection: pin input or internal divider
  wire hclk_sel = cfg_ff.src_sel ? hclk_gen_ff
                                 : hext_s;
  // internal master clock is driven out; external mode leaves pin input
  assign rx_master_clock_out = hclk_gen_ff;
  assign rx_master_clock_oe  = cfg_ff.src_sel;

  // polarity into the bit clock divider
  wire hclk_pol = cfg_ff.invert ? ~hclk_sel : hclk_sel;

  // ---------------- bit clock divider ----------------
  // divides the polarised master clock by bdiv+1
  logic       hpol_d_ff;
  logic [4:0] bcnt_ff;
  logic       bclk_div_ff;
  wire        hpol_rise = hclk_pol & ~hpol_d_ff;
  wire [5:0]  bdiv_n    = {1'b0, cfg_ff.bdiv} + 6'h01;
  wire [4:0]  bhalf     = bdiv_n[5:1];
  wire [4:0]  nxt_bcnt  = (bcnt_ff >= cfg_ff.bdiv) ? 5'h00
                                                   : bcnt_ff + 5'h01;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      hpol_d_ff   <= 1'b0;
      bcnt_ff     <= 5'h00;
      bclk_div_ff <= 1'b0;
    end else if (clk_en) begin
      hpol_d_ff <= hclk_pol;
      if (hpol_rise && cfg_ff.bdiv != 5'h00) begin
        bcnt_ff     <= nxt_bcnt;
        bclk_div_ff <= (nxt_bcnt < bhalf);
      end
    end
  end

  // divide-by-1 passes the master clock straight through
  wire bclk_int = (cfg_ff.bdiv == 5'h00) ? hclk_sel : bclk_div_ff;
  // bit clock source: divider when internal, pin otherwise
  wire bclk     = cfg_ff.bsrc_sel ? bclk_int : bext_s;

  // bit clock pin is driven only when internally generated
  logic bclk_out_ff;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      bclk_out_ff <= 1'b0;
    end else if (clk_en) begin
      bclk_out_ff <= bclk_int;
    end
  end
  assign rx_bit_clock_out = bclk_out_ff;
  assign rx_bit_clock_oe  = cfg_ff.bsrc_sel;

  // ---------------- slot sequencing ----------------
  // a slot is one word of bits; word length fixed by parameter here
  localparam int BITS_PER_SLOT = 32;
  rxmc_slot_state_e state_ff;
  logic             bclk_d_ff;
  logic             frame_d_ff;
  logic [4:0]       bitcnt_ff;
  logic [4:0]       slot_ff;
  logic             shift_ff;
  logic [4:0]       idx_ff;
  wire              bclk_rise  = bclk & ~bclk_d_ff;
  wire              frame_rise = frame_s & ~frame_d_ff;
  wire              last_bit   = (bitcnt_ff == 5'(BITS_PER_SLOT - 1));
  wire              last_slot  = (slot_ff == 5'(SLOTS - 1));
  wire [4:0]        nxt_slot   = last_slot ? 5'h00 : slot_ff + 5'h01;
  // mask lookup by slot index
  wire              slot_on    = rx_slot_active_bits_ff[slot_ff];

  // state and counters; frame start forces slot zero
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff   <= RXMC_SL_IDLE;
      bclk_d_ff  <= 1'b0;
      frame_d_ff <= 1'b0;
      bitcnt_ff  <= 5'h00;
      slot_ff    <= 5'h00;
    end else if (clk_en) begin
      bclk_d_ff  <= bclk;
      frame_d_ff <= frame_s;
      case (state_ff)
        RXMC_SL_IDLE: begin
          if (frame_rise) begin
            state_ff  <= RXMC_SL_RUN;
            bitcnt_ff <= 5'h00;
            slot_ff   <= 5'h00;
          end
        end
        RXMC_SL_RUN: begin
          if (frame_rise) begin
            bitcnt_ff <= 5'h00;
            slot_ff   <= 5'h00;
          end else if (bclk_rise) begin
            bitcnt_ff <= last_bit ? 5'h00 : bitcnt_ff + 5'h01;
            if (last_bit) begin
              slot_ff <= nxt_slot; // one step per slot
            end
          end
        end
        default: begin
          state_ff <= RXMC_SL_IDLE;
        end
      endcase
    end
  end

  // shift enable: one mclk pulse per bit clock rising edge in active slots;
  // the index is registered alongside so a pulse names its own slot
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      shift_ff <= 1'b0;
      idx_ff   <= 5'h00;
    end else if (clk_en) begin
      shift_ff <= (state_ff == RXMC_SL_RUN) && bclk_rise && !frame_rise
                  && slot_on;
      idx_ff   <= slot_ff;
    end
  end

  assign rx_slot_index    = idx_ff;
  assign rx_slot_shift_en = shift_ff;
endmodule

//--- rxmc_asserts.sv
/* rxmc_asserts: port checker for rxmc_top.
   assumes one clock mclk and reset_n active low. */
`timescale 1ns/1ps
module rxmc_asserts (
  input wire logic        mclk,
  input wire logic        reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        rx_master_clock_out,
  input wire logic        rx_master_clock_oe,
  input wire logic        rx_bit_clock_out,
  input wire logic        rx_bit_clock_oe,
  input wire logic        rx_frame_start,
  input wire logic [4:0]  rx_slot_index,
  input wire logic        rx_slot_shift_en
);
  logic        wr;
  logic        src_ff;
  logic [5:0]  bctl_ff;
  logic [31:0] mask_ff;
  // shadows of the fields written over the bus
  assign wr = psel && penable && pwrite;
  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n) begin
      src_ff  <= 1'b1;
      bctl_ff <= 6'h00;
      mask_ff <= 32'h0000_0000;
    end else if (wr) begin
      if (paddr == 8'h74) src_ff <= pwdata[15];
      if (paddr == 8'h70) bctl_ff <= pwdata[5:0];
      if (paddr == 8'h78) mask_ff <= pwdata;
    end
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // outputs tied to the programmed fields, then shift pulse and slot index checks
  rsvd_zero_a: assert property (
    psel && penable && !pwrite && paddr == 8'h74 |->
    !prdata[31:16] && !prdata[13:12]) else $error("reserved nonzero");
  mclk_oe_a: assert property (
    src_ff == $past(src_ff) |-> rx_master_clock_oe == src_ff)
    else $error("master enable wrong");
  bclk_oe_a: assert property (
    bctl_ff[5] == $past(bctl_ff[5]) |-> rx_bit_clock_oe == bctl_ff[5])
    else $error("bit enable wrong");
  pass_thru_a: assert property (
    src_ff && bctl_ff == 6'h20 && $rose(rx_master_clock_out) |->
    ##[0:3] rx_bit_clock_out) else $error("no pass through");
  one_pulse_a: assert property (
    rx_slot_shift_en |=> !rx_slot_shift_en) else $error("long pulse");
  mask_gate_a: assert property (
    rx_slot_shift_en |-> mask_ff[rx_slot_index])
    else $error("masked slot shift");
  slot_step_a: assert property (
    $changed(rx_slot_index) |-> rx_slot_index == 5'h00 ||
    rx_slot_index == $past(rx_slot_index) + 5'h01)
    else $error("slot skipped");
  frame_zero_a: assert property (
    $rose(rx_frame_start) |-> ##[2:6] rx_slot_index == 5'h00)
    else $error("frame did not clear slot");
  shift_c: cover property (rx_slot_shift_en);
  ext_c: cover property (!rx_master_clock_oe);
  pass_c: cover property (bctl_ff == 6'h20 && rx_bit_clock_out);
endmodule

bind rxmc_top rxmc_asserts chk (.*);

//--- rxmc_clk_model.sv
/* rxmc_clk_model: far-side clocks and frame sync for rxmc_top.
   assumes bench mclk; outputs move just after its rising edge. */
`timescale 1ns/1ps
module rxmc_clk_model (
  input  wire logic mclk,
  input  wire logic run,
  input  wire logic frame,
  output logic      auxiliary_source_clock,
  output logic      rx_master_clock_in,
  output logic      rx_bit_clock_in,
  output logic      rx_frame_start
);
  logic [3:0] cnt_ff;
  // aux period 8, pin master 16, bit clock 8 and still while run is low
  initial begin
    cnt_ff = 4'h0;
    {auxiliary_source_clock, rx_master_clock_in} = 2'h0;
    {rx_bit_clock_in, rx_frame_start} = 2'h0;
  end
  always @(posedge mclk) begin
    cnt_ff <= cnt_ff + 4'h1;
    auxiliary_source_clock <= cnt_ff[2];
    rx_master_clock_in <= cnt_ff[3];
    rx_bit_clock_in <= run & cnt_ff[2];
    rx_frame_start <= frame;
  end
endmodule

//--- rxmc_tb_top.sv
/* rxmc_tb_top: directed bench for rxmc_top.
   assumes rxmc_clk_model and the bound checker are compiled first. */
`timescale 1ns/1ps
module rxmc_tb_top;
  logic        mclk, reset_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        auxiliary_source_clock, rx_master_clock_in, rx_bit_clock_in;
  logic        rx_master_clock_out, rx_master_clock_oe, rx_bit_clock_out;
  logic        rx_bit_clock_oe, rx_frame_start, rx_slot_shift_en;
  logic [4:0]  rx_slot_index;
  logic        run, frame, sel, w_d, err;
  int          fail_count, n_tests, p;
  int          slot_cnt [32];
  wire         w = sel ? rx_bit_clock_out : rx_master_clock_out;

  rxmc_clk_model src (.*);
  rxmc_top dut (.clk_en(1'b1), .*);

  // clock, watched clock history and shift pulses per slot
  always #12.5 mclk = ~mclk;
  always @(posedge mclk) begin
    w_d <= w;
    if (rx_slot_shift_en === 1'b1) slot_cnt[rx_slot_index]++;
  end

  task automatic chk(input logic [31:0] g, e);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // one bus transfer, held until pready is seen at an edge
  task automatic apb(input logic wt, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    psel   <= 1'b1;
    pwrite <= wt;
    paddr  <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  // cycles until the next rise of the watched clock
  task automatic rise(output int k);
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (!(w === 1'b1 && w_d === 1'b0) && k < 2000);
  endtask

  task automatic per(output int q);
    rise(q);
    rise(q);
    rise(q);
  endtask

  task automatic t_regs();
    apb(0, 8'h74, 0, rd);
    chk(rd, 32'h0000_8000);
    apb(1, 8'h74, 32'hFFFF_FFFF, rd);
    apb(0, 8'h74, 0, rd);
    chk(rd, 32'h0000_CFFF);
    apb(1, 8'h78, 32'hA5C3_0F96, rd);
    apb(0, 8'h78, 0, rd);
    chk(rd, 32'hA5C3_0F96);
    apb(0, 8'h7C, 0, rd);
    chk({31'h0, err}, 32'h1);
  endtask

  task automatic t_div();
    sel = 0;
    for (int n = 0; n < 8; n += 3) begin
      apb(1, 8'h74, 32'h8000 | n, rd);
      per(p);
      chk(p, 8 * (n + 1));
    end
  endtask

  task automatic t_ext();
    apb(1, 8'h74, 0, rd);
    apb(1, 8'h70, 32'h20, rd);
    sel = 1;
    per(p);
    chk(p, 16);
    chk({31'h0, rx_master_clock_oe}, 0);
  endtask

  task automatic t_bit();
    apb(1, 8'h74, 32'h8000, rd);
    for (int b = 0; b < 4; b += 3) begin
      apb(1, 8'h70, 32'h20 | b, rd);
      per(p);
      chk(p, 8 * (b + 1));
    end
    chk({31'h0, rx_bit_clock_oe}, 1);
  endtask

  task automatic t_inv();
    apb(1, 8'h70, 32'h21, rd);
    for (int i = 0; i < 2; i++) begin
      apb(1, 8'h74, 32'h8001 | (i << 14), rd);
      per(p);
      chk({31'h0, rx_master_clock_out}, 1 - i);
    end
  endtask

  task automatic t_slot();
    apb(1, 8'h70, 0, rd);
    apb(1, 8'h78, 32'h0000_0005, rd);
    foreach (slot_cnt[i]) slot_cnt[i] = 0;
    frame <= 1'b1;
    repeat (8) @(posedge mclk);
    run <= 1'b1;
    repeat (800) @(posedge mclk);
    run <= 1'b0;
    chk(slot_cnt[0], 32);
    chk(slot_cnt[1], 0);
    chk(slot_cnt[2], 32);
    chk({31'h0, rx_bit_clock_oe}, 0);
  endtask

  // reset for ten cycles, then the scenarios
  initial begin
    {mclk, reset_n, psel, penable, pwrite, run, frame, sel} = 8'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    t_regs();
    t_div();
    t_ext();
    t_bit();
    t_inv();
    t_slot();
    stop_test();
  end

  // watchdog far beyond the few thousand cycles needed
  initial begin
    #500000;
    fail_count++;
    stop_test();
  end
endmodule
